// *** hw/esa_aggregator.sv ***
// error signal aggregator: sticky fault flags, two interrupt levels, error pin
// Functional notes
// - every diagnostic source has its own input into one aggregation unit.
// - each source has a severity class and a programmable response.
// - software enables or masks each input; enabled inputs raise low or high interrupt.
// - active-low error pin signals high-severity faults the processor left unhandled.
// - radar cube memory keeps 8 check bits per 64 data bits, secded.
// - radar cube ecc errors feed the aggregator and interrupt the processor.
// - safety monitor watchdog timeout becomes an interrupt; software picks the reset.
// - signal-processor watchdog stays inactive until armed; its timeout interrupts.
// - peripheral buffer ecc reporting is off after reset until both enables set.
`timescale 1ns/10ps
`default_nettype none
`include "esa_map.svh"
module esa_aggregator
    import esa_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       cube_wr_en,
    input  wire esa_addr_t  cube_wr_addr,
    input  wire esa_data_t  cube_wr_data,
    input  wire logic [1:0] cube_inject,
    input  wire logic       cube_rd_en,
    input  wire esa_addr_t  cube_rd_addr,
    output logic [63:0]     cube_rd_data,
    output logic            cube_rd_valid,
    input  wire logic       safety_wdt_timeout,
    input  wire logic       sigproc_wdt_arm,
    input  wire logic       sigproc_wdt_timeout,
    input  wire logic       periph_ecc_single,
    input  wire logic       periph_ecc_double,
    input  wire logic       periph_ecc_en_periph,
    input  wire logic       periph_ecc_en_agg,
    input  wire logic       clk_mon_fail,
    input  wire logic       aux_fault,
    input  wire esa_src_t   src_enable,
    input  wire esa_src_t   src_high_pri,
    input  wire esa_src_t   pend_clear,
    input  wire logic       err_pin_clear,
    output esa_src_t        pending,
    output logic            irq_high,
    output logic            irq_low,
    output logic            error_n
);

    localparam int         ESA_PIN_CYC   = (`ESA_ERR_PIN_WAIT_NS + `ESA_CLK_PERIOD_NS - 1)
                                           / `ESA_CLK_PERIOD_NS;
    localparam logic [15:0] ESA_PIN_LOAD = 16'(ESA_PIN_CYC - 1);
    localparam int         ESA_PIN_BOUND = 505;

    esa_cube_if cube ();

    esa_src_t       pend_reg;
    esa_src_t       pend_next;
    esa_src_t       src_vec;
    logic           periph_gate_reg;
    logic           sigproc_armed_reg;
    logic           irq_high_reg;
    logic           irq_low_reg;
    logic           error_n_reg;
    logic           hi_out;
    esa_pin_state_e pin_reg;
    esa_pin_state_e pin_next;
    logic [15:0]    pin_timer_reg;

    assign cube.wr_en   = cube_wr_en;
    assign cube.wr_addr = cube_wr_addr;
    assign cube.wr_data = cube_wr_data;
    assign cube.inject  = cube_inject;
    assign cube.rd_en   = cube_rd_en;
    assign cube.rd_addr = cube_rd_addr;

    esa_cube_mem u_cube (
        .core_clk (core_clk),
        .reset    (reset),
        .cube     (cube.mem)
    );

    // enables held in flops so reporting is off from reset onward
    always_ff @(posedge core_clk) begin
        if (reset) begin
            periph_gate_reg <= 1'b0;
        end else begin
            periph_gate_reg <= periph_ecc_en_periph & periph_ecc_en_agg;
        end
    end

    // once armed the watchdog path stays live until reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sigproc_armed_reg <= 1'b0;
        end else if (sigproc_wdt_arm) begin
            sigproc_armed_reg <= 1'b1;
        end
    end

    always_comb begin
        src_vec = '0;
        src_vec[`ESA_SRC_CUBE_SEC]    = cube.sec_err;
        src_vec[`ESA_SRC_CUBE_DED]    = cube.ded_err;
        src_vec[`ESA_SRC_SAFETY_WDT]  = safety_wdt_timeout;
        src_vec[`ESA_SRC_SIGPROC_WDT] = sigproc_wdt_timeout & sigproc_armed_reg;
        src_vec[`ESA_SRC_PERIPH_SEC]  = periph_ecc_single & periph_gate_reg;
        src_vec[`ESA_SRC_PERIPH_DED]  = periph_ecc_double & periph_gate_reg;
        src_vec[`ESA_SRC_CLK_MON]     = clk_mon_fail;
        src_vec[`ESA_SRC_AUX]         = aux_fault;
    end

    // a new event beats a clear in the same cycle; mask does not gate the flag
    assign pend_next = (pend_reg & ~pend_clear) | src_vec;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_reg <= `ESA_PEND_RESET;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // class picks the line; enable is the response
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_high_reg <= 1'b0;
            irq_low_reg  <= 1'b0;
        end else begin
            irq_high_reg <= hi_out;
            irq_low_reg  <= |(pend_reg & src_enable & ~src_high_pri);
        end
    end

    assign hi_out = |(pend_reg & src_enable & src_high_pri);

    // unhandled means a high flag still pending after the wait expires
    always_comb begin
        pin_next = pin_reg;
        case (pin_reg)
            ESA_PIN_IDLE: begin
                if (hi_out) begin
                    pin_next = ESA_PIN_WAIT;
                end
            end
            ESA_PIN_WAIT: begin
                if (!hi_out) begin
                    pin_next = ESA_PIN_IDLE;
                end else if (pin_timer_reg == 16'h0000) begin
                    pin_next = ESA_PIN_FAULT;
                end
            end
            ESA_PIN_FAULT: begin
                if (err_pin_clear) begin
                    pin_next = ESA_PIN_IDLE;
                end
            end
            default: begin
                pin_next = ESA_PIN_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_reg <= ESA_PIN_IDLE;
        end else begin
            pin_reg <= pin_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_timer_reg <= 16'h0000;
        end else if (pin_reg != ESA_PIN_WAIT) begin
            pin_timer_reg <= ESA_PIN_LOAD;
        end else if (pin_timer_reg != 16'h0000) begin
            pin_timer_reg <= pin_timer_reg - 16'h0001;
        end
    end

    // pin latches low; only software releases it, so a glitchy fault cannot hide
    always_ff @(posedge core_clk) begin
        if (reset) begin
            error_n_reg <= `ESA_ERR_N_RESET;
        end else begin
            error_n_reg <= (pin_next != ESA_PIN_FAULT);
        end
    end

    assign pending       = pend_reg;
    assign irq_high      = irq_high_reg;
    assign irq_low       = irq_low_reg;
    assign error_n       = error_n_reg;
    assign cube_rd_data  = cube.rd_data;
    assign cube_rd_valid = cube.rd_valid;

    property p_pend_set;
        @(posedge core_clk) disable iff (reset)
        (|src_vec) |=> ((pend_reg & $past(src_vec)) == $past(src_vec));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("event did not set its flag");

    property p_pend_hold;
        @(posedge core_clk) disable iff (reset)
        (|(pend_reg & ~pend_clear)) |=>
            ((pend_reg & $past(pend_reg & ~pend_clear)) == $past(pend_reg & ~pend_clear));
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("flag dropped without clear");

    property p_irq_high;
        @(posedge core_clk) disable iff (reset)
        (|(pend_reg & src_enable & src_high_pri)) |=> irq_high;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("high interrupt missing");

    property p_irq_low_quiet;
        @(posedge core_clk) disable iff (reset)
        !(|(pend_reg & src_enable & ~src_high_pri)) |=> !irq_low;
    endproperty
    a_irq_low_quiet: assert property (p_irq_low_quiet) else $error("low interrupt spurious");

    property p_masked;
        @(posedge core_clk) disable iff (reset)
        ((pend_reg & src_enable) == '0) |=> (!irq_high && !irq_low);
    endproperty
    a_masked: assert property (p_masked) else $error("masked source raised interrupt");

    property p_periph_gate;
        @(posedge core_clk) disable iff (reset)
        !periph_gate_reg |-> !src_vec[`ESA_SRC_PERIPH_SEC] && !src_vec[`ESA_SRC_PERIPH_DED];
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral ecc not gated");

    property p_sigproc_idle;
        @(posedge core_clk) disable iff (reset)
        (!sigproc_armed_reg && sigproc_wdt_timeout) |=> !pend_reg[`ESA_SRC_SIGPROC_WDT]
            || $past(pend_reg[`ESA_SRC_SIGPROC_WDT]);
    endproperty
    a_sigproc_idle: assert property (p_sigproc_idle) else $error("unarmed watchdog reported");

    property p_safety_wdt;
        @(posedge core_clk) disable iff (reset)
        safety_wdt_timeout |=> pend_reg[`ESA_SRC_SAFETY_WDT];
    endproperty
    a_safety_wdt: assert property (p_safety_wdt) else $error("safety timeout lost");

    property p_cube_ded;
        @(posedge core_clk) disable iff (reset)
        cube.ded_err |=> pend_reg[`ESA_SRC_CUBE_DED];
    endproperty
    a_cube_ded: assert property (p_cube_ded) else $error("cube double error lost");

    property p_pin_fires;
        @(posedge core_clk) disable iff (reset)
        $rose(hi_out) && pin_reg == ESA_PIN_IDLE |->
            ##[1:ESA_PIN_BOUND] (!error_n || !hi_out);
    endproperty
    a_pin_fires: assert property (p_pin_fires) else $error("error pin not asserted");

    property p_pin_release;
        @(posedge core_clk) disable iff (reset)
        $rose(error_n) |-> $past(err_pin_clear);
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin released without clear");

    property p_pin_early;
        @(posedge core_clk) disable iff (reset)
        (pin_reg == ESA_PIN_WAIT && pin_timer_reg != 16'h0000) |=> error_n;
    endproperty
    a_pin_early: assert property (p_pin_early) else $error("error pin asserted early");

endmodule
`default_nettype wire

// *** hw/esa_cube_if.sv ***
// carrier between the aggregator and the radar cube memory
`timescale 1ns/10ps
`default_nettype none
interface esa_cube_if;
    import esa_pkg::*;
    logic      wr_en;
    esa_addr_t wr_addr;
    esa_data_t wr_data;
    logic [1:0] inject;
    logic      rd_en;
    esa_addr_t rd_addr;
    esa_data_t rd_data;
    logic      rd_valid;
    logic      sec_err;
    logic      ded_err;

    modport mem (input wr_en, wr_addr, wr_data, inject, rd_en, rd_addr,
                 output rd_data, rd_valid, sec_err, ded_err);
    modport ctl (output wr_en, wr_addr, wr_data, inject, rd_en, rd_addr,
                 input rd_data, rd_valid, sec_err, ded_err);
endinterface
`default_nettype wire

// *** hw/esa_cube_mem.sv ***
// radar cube memory with secded protection, 8 check bits per 64 data bits
`timescale 1ns/10ps
`default_nettype none
`include "esa_map.svh"
module esa_cube_mem
    import esa_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    esa_cube_if.mem  cube
);

    esa_cw_t   mem_arr [`ESA_CUBE_DEPTH];
    esa_cw_t   rd_cw;
    esa_data_t fix_data;
    logic      fix_sec;
    logic      fix_ded;

    // hamming positions 1..71, overall parity in bit 0
    function automatic logic [6:0] esa_syndrome(input esa_cw_t cw);
        logic [6:0] s;
        s = 7'h00;
        for (int p = 1; p < `ESA_CW_W; p++) begin
            if (cw[p]) begin
                s = s ^ p[6:0];
            end
        end
        return s;
    endfunction

    function automatic esa_cw_t esa_encode(input esa_data_t d);
        esa_cw_t    cw;
        logic [6:0] s;
        int         j;
        cw = '0;
        j = 0;
        for (int p = 1; p < `ESA_CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p] = d[j];
                j++;
            end
        end
        s = esa_syndrome(cw);
        for (int k = 0; k < 7; k++) begin
            cw[1 << k] = s[k];
        end
        cw[0] = ^cw[`ESA_CW_W-1:1];
        return cw;
    endfunction

    function automatic esa_data_t esa_extract(input esa_cw_t cw);
        esa_data_t d;
        int        j;
        d = '0;
        j = 0;
        for (int p = 1; p < `ESA_CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[j] = cw[p];
                j++;
            end
        end
        return d;
    endfunction

    // inject flips the two lowest stored bits so both error kinds can be provoked
    always_ff @(posedge core_clk) begin
        if (cube.wr_en) begin
            mem_arr[cube.wr_addr] <= esa_encode(cube.wr_data) ^ {70'h0, cube.inject};
        end
    end

    always_comb begin
        logic [6:0] s;
        logic       par;
        s = 7'h00;
        par = 1'b0;
        rd_cw = mem_arr[cube.rd_addr];
        s = esa_syndrome(rd_cw);
        par = ^rd_cw;
        fix_sec = 1'b0;
        fix_ded = 1'b0;
        if (par) begin
            fix_sec = 1'b1;
            if (s != 7'h00 && s < 7'h48) begin
                rd_cw[s] = ~rd_cw[s];
            end
        end else if (s != 7'h00) begin
            fix_ded = 1'b1;
        end
        fix_data = esa_extract(rd_cw);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cube.rd_valid <= 1'b0;
            cube.sec_err  <= 1'b0;
            cube.ded_err  <= 1'b0;
            cube.rd_data  <= '0;
        end else begin
            cube.rd_valid <= cube.rd_en;
            cube.sec_err  <= cube.rd_en & fix_sec;
            cube.ded_err  <= cube.rd_en & fix_ded;
            cube.rd_data  <= cube.rd_en ? fix_data : cube.rd_data;
        end
    end

    property p_cube_one_kind;
        @(posedge core_clk) disable iff (reset)
        cube.rd_valid |-> !(cube.sec_err && cube.ded_err);
    endproperty
    a_cube_one_kind: assert property (p_cube_one_kind) else $error("sec and ded together");

    property p_cube_latency;
        @(posedge core_clk) disable iff (reset)
        cube.rd_valid == $past(cube.rd_en);
    endproperty
    a_cube_latency: assert property (p_cube_latency) else $error("read not answered next cycle");

endmodule
`default_nettype wire

// *** hw/esa_map.svh ***
// constants for the error signal aggregator: source slots, widths, reset values, timing
`ifndef ESA_MAP_SVH
`define ESA_MAP_SVH

`define ESA_NSRC            8
`define ESA_SRC_CUBE_SEC    0
`define ESA_SRC_CUBE_DED    1
`define ESA_SRC_SAFETY_WDT  2
`define ESA_SRC_SIGPROC_WDT 3
`define ESA_SRC_PERIPH_SEC  4
`define ESA_SRC_PERIPH_DED  5
`define ESA_SRC_CLK_MON     6
`define ESA_SRC_AUX         7

`define ESA_DATA_W          64
`define ESA_CHK_W           8
`define ESA_CW_W            72
`define ESA_CUBE_AW         4
`define ESA_CUBE_DEPTH      16

`define ESA_PEND_RESET      8'h00
`define ESA_ERR_N_RESET     1'b1

`define ESA_CLK_PERIOD_NS   20
`define ESA_ERR_PIN_WAIT_NS 10000

`endif

// *** hw/esa_pkg.sv ***
// types shared by the error signal aggregator modules
`default_nettype none
package esa_pkg;
`include "esa_map.svh"

    typedef logic [`ESA_NSRC-1:0]    esa_src_t;
    typedef logic [`ESA_DATA_W-1:0]  esa_data_t;
    typedef logic [`ESA_CW_W-1:0]    esa_cw_t;
    typedef logic [`ESA_CUBE_AW-1:0] esa_addr_t;

    typedef enum logic [1:0] {
        ESA_PIN_IDLE  = 2'b00,
        ESA_PIN_WAIT  = 2'b01,
        ESA_PIN_FAULT = 2'b10
    } esa_pin_state_e;

endpackage
`default_nettype wire

// *** testbench/esa_cpu_model.sv ***
// behavioural model of the control processor and error monitor around the aggregator
`timescale 1ns/10ps
`default_nettype none
module esa_cpu_model
    import esa_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        svc_en,
    input  wire logic [15:0] svc_delay,
    input  wire logic        irq_high,
    input  wire logic        irq_low,
    input  wire logic        error_n,
    input  wire esa_src_t    pending,
    output var  esa_src_t    pend_clear,
    output var  logic        err_pin_clear,
    output var  int unsigned n_svc
);
    int unsigned wait_cnt;

    // software polls or takes the interrupt, then serves after a chosen latency
    always @(posedge core_clk) begin
        if (reset) begin
            pend_clear <= '0;
            err_pin_clear <= 1'b0;
            wait_cnt <= 0;
            n_svc <= 0;
        end else if (svc_en && (irq_high || irq_low || !error_n || pending != '0)) begin
            if (wait_cnt >= svc_delay) begin
                // clearing stands in for the subsystem or device reset picked by software
                pend_clear <= pending;
                err_pin_clear <= !error_n;
                n_svc <= n_svc + 1;
                wait_cnt <= 0;
            end else begin
                pend_clear <= '0;
                err_pin_clear <= 1'b0;
                wait_cnt <= wait_cnt + 1;
            end
        end else begin
            pend_clear <= '0;
            err_pin_clear <= 1'b0;
            wait_cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the error signal aggregator
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import esa_pkg::*;
();
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        cube_wr_en = 1'b0;
    logic        cube_rd_en = 1'b0;
    esa_addr_t   cube_wr_addr = '0;
    esa_addr_t   cube_rd_addr = '0;
    esa_data_t   cube_wr_data = '0;
    logic [1:0]  cube_inject = 2'h0;
    logic [63:0] cube_rd_data;
    logic        cube_rd_valid;
    esa_src_t    src_in = '0;
    logic        sigproc_wdt_arm = 1'b0;
    logic        en_periph = 1'b0;
    logic        en_agg = 1'b0;
    esa_src_t    src_enable = '0;
    esa_src_t    src_high_pri = '0;
    esa_src_t    pend_clear;
    esa_src_t    pending;
    logic        err_pin_clear;
    logic        irq_high;
    logic        irq_low;
    logic        error_n;
    logic        svc_en = 1'b0;
    logic [15:0] svc_delay = 16'h0003;
    int unsigned n_svc;
    int          n_fail = 0;
    int          checks_done = 0;

    always #10 core_clk = ~core_clk;

    esa_aggregator esa_aggregator_i (
        .core_clk(core_clk), .reset(reset),
        .cube_wr_en(cube_wr_en), .cube_wr_addr(cube_wr_addr), .cube_wr_data(cube_wr_data),
        .cube_inject(cube_inject), .cube_rd_en(cube_rd_en), .cube_rd_addr(cube_rd_addr),
        .cube_rd_data(cube_rd_data), .cube_rd_valid(cube_rd_valid),
        .safety_wdt_timeout(src_in[2]), .sigproc_wdt_arm(sigproc_wdt_arm),
        .sigproc_wdt_timeout(src_in[3]), .periph_ecc_single(src_in[4]),
        .periph_ecc_double(src_in[5]), .periph_ecc_en_periph(en_periph),
        .periph_ecc_en_agg(en_agg), .clk_mon_fail(src_in[6]), .aux_fault(src_in[7]),
        .src_enable(src_enable), .src_high_pri(src_high_pri), .pend_clear(pend_clear),
        .err_pin_clear(err_pin_clear), .pending(pending), .irq_high(irq_high),
        .irq_low(irq_low), .error_n(error_n));

    esa_cpu_model esa_cpu_model_i (
        .core_clk(core_clk), .reset(reset), .svc_en(svc_en), .svc_delay(svc_delay),
        .irq_high(irq_high), .irq_low(irq_low), .error_n(error_n), .pending(pending),
        .pend_clear(pend_clear), .err_pin_clear(err_pin_clear), .n_svc(n_svc));

    task automatic wrap_up;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one-cycle strobe on a plain source; returns just after the edge that took it
    task automatic pulse(input int idx);
        @(posedge core_clk);
        src_in[idx] <= 1'b1;
        @(posedge core_clk);
        src_in[idx] <= 1'b0;
        #1;
    endtask

    // let the processor model clear flags and pin, bounded
    task automatic service;
        int k;
        @(posedge core_clk);
        svc_en <= 1'b1;
        for (k = 0; k < 60 && (pending !== '0 || error_n !== 1'b1); k++)
            step(1);
        chk("service done", 1, k < 60);
        if (k >= 60)
            wrap_up;
        @(posedge core_clk);
        svc_en <= 1'b0;
        step(2);
    endtask

    task automatic t_reset;
        chk("pending after reset", 8'h00, pending);
        chk("irq high after reset", 0, irq_high);
        chk("irq low after reset", 0, irq_low);
        chk("error pin after reset", 1, error_n);
        chk("read valid after reset", 0, cube_rd_valid);
        $display("test reset done");
    endtask

    task automatic t_refuse;
        @(posedge core_clk);
        src_enable <= 8'hFF;
        pulse(3);
        step(1);
        chk("watchdog before arm", 8'h00, pending);
        pulse(4);
        step(1);
        chk("periph ecc gates off", 8'h00, pending);
        @(posedge core_clk);
        en_periph <= 1'b1;
        pulse(5);
        step(1);
        chk("periph ecc one gate", 8'h00, pending);
        @(posedge core_clk);
        sigproc_wdt_arm <= 1'b1;
        en_agg <= 1'b1;
        @(posedge core_clk);
        sigproc_wdt_arm <= 1'b0;
        step(2);
        $display("test refuse done");
    endtask

    task automatic t_sources;
        int i;
        logic hp;
        for (i = 2; i < 8; i++) begin
            hp = i[0];
            @(posedge core_clk);
            src_enable <= 8'hFF;
            src_high_pri <= {8{hp}};
            pulse(i);
            chk("pending one source", 64'h1 << i, pending);
            step(1);
            chk("irq high class", hp, irq_high);
            chk("irq low class", !hp, irq_low);
            @(posedge core_clk);
            src_enable <= ~esa_src_t'(1 << i);
            step(3);
            chk("masked irq high", 0, irq_high);
            chk("masked irq low", 0, irq_low);
            chk("masked flag sticky", 64'h1 << i, pending);
            service;
        end
        $display("test sources done");
    endtask

    task automatic t_cube;
        logic [1:0] inj [3] = '{2'h0, 2'h1, 2'h3};
        esa_src_t   exp_p [3] = '{8'h00, 8'h01, 8'h02};
        esa_data_t  d;
        int         i;
        for (i = 0; i < 3; i++) begin
            d = 64'hC3A5_0F1E_9B7D_2468 ^ i;
            @(posedge core_clk);
            src_enable <= 8'hFF;
            src_high_pri <= 8'h02;
            cube_wr_en <= 1'b1;
            cube_wr_addr <= esa_addr_t'(i + 5);
            cube_wr_data <= d;
            cube_inject <= inj[i];
            @(posedge core_clk);
            cube_wr_en <= 1'b0;
            cube_inject <= 2'h0;
            cube_rd_en <= 1'b1;
            cube_rd_addr <= esa_addr_t'(i + 5);
            @(posedge core_clk);
            cube_rd_en <= 1'b0;
            #1;
            chk("read valid", 1, cube_rd_valid);
            if (i < 2)
                chk("read data corrected", d, cube_rd_data);
            step(1);
            chk("cube ecc flag", exp_p[i], pending);
            step(1);
            chk("cube irq high", i == 2, irq_high);
            chk("cube irq low", i == 1, irq_low);
            service;
        end
        $display("test cube done");
    endtask

    task automatic t_pin_slow;
        int n;
        @(posedge core_clk);
        src_enable <= 8'hFF;
        src_high_pri <= 8'hFF;
        pulse(6);
        for (n = 0; n < 600 && error_n !== 1'b0; n++)
            step(1);
        chk("pin wait edges", 1, n >= 499 && n <= 502);
        if (n >= 600)
            wrap_up;
        @(posedge core_clk);
        src_enable <= 8'h00;
        step(3);
        chk("pin latched after mask", 0, error_n);
        service;
        chk("pin released", 1, error_n);
        $display("test pin slow done");
    endtask

    task automatic t_prompt;
        int          k;
        int unsigned base;
        logic        pin_low;
        logic        seen;
        base = n_svc;
        pin_low = 1'b0;
        seen = 1'b0;
        @(posedge core_clk);
        svc_en <= 1'b1;
        src_enable <= 8'hFF;
        pulse(2);
        for (k = 0; k < 600; k++) begin
            step(1);
            if (error_n !== 1'b1)
                pin_low = 1'b1;
            if (irq_high === 1'b1)
                seen = 1'b1;
        end
        chk("pin high when served", 0, pin_low);
        chk("watchdog irq raised", 1, seen);
        chk("watchdog served", 1, n_svc != base);
        chk("flags cleared", 8'h00, pending);
        @(posedge core_clk);
        svc_en <= 1'b0;
        $display("test prompt done");
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        step(1);
        t_reset;
        t_refuse;
        t_sources;
        t_cube;
        t_pin_slow;
        t_prompt;
        wrap_up;
    end
endmodule
`default_nettype wire
